// ### rtl/pin_override_params.svh
// pad override constants for the port b / port c alternate function block
// assumes inclusion by bare name from the package and the design module
`ifndef PIN_OVERRIDE_PARAMS_SVH
`define PIN_OVERRIDE_PARAMS_SVH

// port width
`define PORT_WIDTH         8
// port b pin positions
`define PB_SLAVE_SEL       0
`define PB_SERIAL_CLK      1
`define PB_MOSI_PIN        2
`define PB_MISO_PIN        3
`define PB_COUNT_PIN       4
// port c pin positions
`define PC_RESET_PIN       1
`define PC_PCS11_PIN       2
`define PC_PCS10_PIN       4
`define PC_CMP_B_PIN       5
`define PC_CMP_A_PIN       6
`define PC_CAPTURE_PIN     7
// pull-up default pattern {dir, latch, global disable}
`define PULLUP_DEFAULT_PAT 3'h2
// number of port b pins with pin change sources
`define PB_PCS_COUNT       7
// fuse reading meaning unprogrammed
`define FUSE_UNPROGRAMMED  1'h1

`endif

// ### rtl/pin_override_pkg.sv
// types shared by the port override logic
// assumes the constants header is on the include path
`include "pin_override_params.svh"
package pin_override_pkg;
  typedef logic [`PORT_WIDTH-1:0] port_vec_t;
  typedef enum logic [3:0] {
    SPI_OFF    = 4'h1,
    SPI_SLAVE  = 4'h2,
    SPI_MASTER = 4'h4,
    SPI_RSVD   = 4'h8
  } spi_role_t;
endpackage

// ### rtl/port_b_c_alternate_function_override.sv
// pad override logic for the port b and port c alternate functions
// assumes pads are resolved outside; all inputs synchronous to clk_i
`include "pin_override_params.svh"

module port_b_c_alternate_function_override (
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  input  wire pin_override_pkg::port_vec_t portb_dir_i,
  input  wire pin_override_pkg::port_vec_t portb_latch_i,
  input  wire pin_override_pkg::port_vec_t portb_pad_i,
  input  wire pin_override_pkg::port_vec_t portc_dir_i,
  input  wire pin_override_pkg::port_vec_t portc_latch_i,
  input  wire pin_override_pkg::port_vec_t portc_pad_i,
  input  wire logic                      global_pullup_disable_i,
  input  wire logic                      sleep_i,
  input  wire logic                      spi_enable_bit_i,
  input  wire logic                      spi_master_select_i,
  input  wire logic                      spi_slave_out_i,
  input  wire logic                      spi_master_out_i,
  input  wire logic                      spi_clock_out_i,
  input  wire logic                      prog_mode_i,
  input  wire logic                      prog_data_out_i,
  input  wire pin_override_pkg::port_vec_t pcs_mask_b_i,
  input  wire logic [3:0]                pcs_mask_c_i,
  input  wire logic                      pin_change_group_enable_i,
  input  wire logic                      pin_change_group_c_enable_i,
  input  wire logic                      timer1_compare_a_en_i,
  input  wire logic                      timer1_compare_a_out_i,
  input  wire logic                      timer1_compare_b_en_i,
  input  wire logic                      timer1_compare_b_out_i,
  input  wire logic                      ext_irq_4_enable_i,
  input  wire logic                      sys_clock_output_fuse_i,
  input  wire logic                      sys_clock_i,
  input  wire logic                      reset_disable_fuse_i,
  input  wire logic                      debug_enable_fuse_i,
  input  wire logic                      lock_bits_unprog_i,
  input  wire logic                      debug_tx_low_i,
  output logic [`PORT_WIDTH-1:0]         portb_out_o,
  output logic [`PORT_WIDTH-1:0]         portb_oe_n_o,
  output logic [`PORT_WIDTH-1:0]         portb_pullup_o,
  output logic [`PORT_WIDTH-1:0]         portb_din_o,
  output logic [`PORT_WIDTH-1:0]         portc_out_o,
  output logic [`PORT_WIDTH-1:0]         portc_oe_n_o,
  output logic [`PORT_WIDTH-1:0]         portc_pullup_o,
  output logic [`PORT_WIDTH-1:0]         portc_din_o,
  output logic                           spi_master_in_o,
  output logic                           spi_slave_in_o,
  output logic                           spi_clock_in_o,
  output logic                           spi_slave_active_o,
  output logic                           prog_data_in_o,
  output logic                           prog_clock_o,
  output logic [11:0]                    pin_change_source_o,
  output logic                           timer1_count_input_o,
  output logic                           timer1_capture_input_o,
  output logic                           ext_irq_source_4_o,
  output logic                           ext_reset_n_o,
  output logic                           one_wire_debug_line_o
);
  import pin_override_pkg::*;

  // ==========================================================
  // override signal generation
  spi_role_t spi_role;
  port_vec_t b_pullup_override_en, b_pullup_override_val, b_dir_override_en, b_dir_override_val, b_value_override_en, b_value_override_val, b_din_enable_override_en;
  port_vec_t c_pullup_override_en, c_pullup_override_val, c_dir_override_en, c_dir_override_val, c_value_override_en, c_value_override_val, c_din_enable_override_en;
  port_vec_t b_din_en, c_din_en;
  logic      reset_pin_en;
  logic      debug_active;

  // one pad: pull-up, driver enable and driven value after overrides
  function automatic logic [2:0] pad_resolve(
    input logic pullup_override_en, input logic pullup_override_val, input logic dir_override_en,
    input logic dir_override_val, input logic value_override_en, input logic value_override_val,
    input logic dir,  input logic latch, input logic global_pullup_disable);
    logic pu;
    logic de;
    logic val;
    pu  = pullup_override_en ? pullup_override_val
               : ({dir, latch, global_pullup_disable} == `PULLUP_DEFAULT_PAT);
    de  = dir_override_en ? dir_override_val : dir;
    val = value_override_en ? value_override_val : latch;
    return {pu, de, val};
  endfunction

  // spi role from enable and master select
  always_comb begin
    if (!spi_enable_bit_i) spi_role = SPI_OFF;
    else if (spi_master_select_i) spi_role = SPI_MASTER;
    else spi_role = SPI_SLAVE;
  end

  assign reset_pin_en = (reset_disable_fuse_i == `FUSE_UNPROGRAMMED);
  assign debug_active = debug_enable_fuse_i & lock_bits_unprog_i;

  // port b override terms
  always_comb begin
    b_pullup_override_en  = '0;
    b_pullup_override_val  = '0;
    b_dir_override_en  = '0;
    b_dir_override_val  = '0;
    b_value_override_en  = '0;
    b_value_override_val  = '0;
    // pin change mask bits 0..7 gate their digital input on
    b_din_enable_override_en = pcs_mask_b_i & {`PORT_WIDTH{pin_change_group_enable_i}};
    case (spi_role)
      SPI_MASTER: begin
        // master: miso forced in, others follow direction bits
        b_pullup_override_en[`PB_MISO_PIN] = 1'b1;
        b_dir_override_en[`PB_MISO_PIN] = 1'b1;
        b_value_override_en[`PB_MOSI_PIN] = 1'b1;
        b_value_override_val[`PB_MOSI_PIN] = spi_master_out_i;
        b_value_override_en[`PB_SERIAL_CLK] = 1'b1;
        b_value_override_val[`PB_SERIAL_CLK] = spi_clock_out_i;
      end
      SPI_SLAVE: begin
        // slave: mosi, clock and select forced in
        b_pullup_override_en[`PB_SERIAL_CLK] = 1'b1;
        b_dir_override_en[`PB_SERIAL_CLK] = 1'b1;
        b_pullup_override_en[`PB_MOSI_PIN] = 1'b1;
        b_dir_override_en[`PB_MOSI_PIN] = 1'b1;
        b_pullup_override_en[`PB_SLAVE_SEL] = 1'b1;
        b_dir_override_en[`PB_SLAVE_SEL] = 1'b1;
        b_value_override_en[`PB_MISO_PIN] = 1'b1;
        b_value_override_val[`PB_MISO_PIN] = spi_slave_out_i;
      end
      default: begin
      end
    endcase
    // forced inputs keep latch-driven pull-up unless globally disabled
    b_pullup_override_val[3:0] = portb_latch_i[3:0]
                  & {4{~global_pullup_disable_i}};
    // programming download takes miso for its data output
    if (prog_mode_i) begin
      b_dir_override_en[`PB_MISO_PIN] = 1'b1;
      b_dir_override_val[`PB_MISO_PIN] = 1'b1;
      b_value_override_en[`PB_MISO_PIN] = 1'b1;
      b_value_override_val[`PB_MISO_PIN] = prog_data_out_i;
      b_pullup_override_en[`PB_MISO_PIN] = 1'b0;
    end
  end

  // port c override terms
  always_comb begin
    c_pullup_override_en  = '0;
    c_pullup_override_val  = '0;
    c_dir_override_en  = '0;
    c_dir_override_val  = '0;
    c_value_override_en  = '0;
    c_value_override_val  = '0;
    c_din_enable_override_en = '0;
    c_din_enable_override_en[`PC_CMP_A_PIN]  = pcs_mask_c_i[0] & pin_change_group_c_enable_i;
    c_din_enable_override_en[`PC_CMP_B_PIN]  = pcs_mask_c_i[1] & pin_change_group_c_enable_i;
    c_din_enable_override_en[`PC_PCS10_PIN]  = pcs_mask_c_i[2] & pin_change_group_c_enable_i;
    c_din_enable_override_en[`PC_PCS11_PIN]  = pcs_mask_c_i[3] & pin_change_group_c_enable_i;
    c_din_enable_override_en[`PC_CAPTURE_PIN] = ext_irq_4_enable_i;
    // compare outputs override value only; driver stays on direction bit
    c_value_override_en[`PC_CMP_A_PIN] = timer1_compare_a_en_i;
    c_value_override_val[`PC_CMP_A_PIN] = timer1_compare_a_out_i;
    c_value_override_en[`PC_CMP_B_PIN] = timer1_compare_b_en_i;
    c_value_override_val[`PC_CMP_B_PIN] = timer1_compare_b_out_i;
    if (sys_clock_output_fuse_i) begin
      c_dir_override_en[`PC_CAPTURE_PIN] = 1'b1;
      c_dir_override_val[`PC_CAPTURE_PIN] = 1'b1;
      c_value_override_en[`PC_CAPTURE_PIN] = 1'b1;
      c_value_override_val[`PC_CAPTURE_PIN] = sys_clock_i;
    end
    if (reset_pin_en || debug_active) begin
      c_pullup_override_en[`PC_RESET_PIN] = 1'b1;
      c_pullup_override_val[`PC_RESET_PIN] = 1'b1;
      c_dir_override_en[`PC_RESET_PIN] = 1'b1;
      // open drain: drive only a low for the debug line
      c_dir_override_val[`PC_RESET_PIN] = debug_active & debug_tx_low_i;
      c_value_override_en[`PC_RESET_PIN] = 1'b1;
      c_value_override_val[`PC_RESET_PIN] = 1'b0;
    end
  end

  // digital input enable, sleep gates it unless overridden
  always_comb begin
    b_din_en = b_din_enable_override_en | {`PORT_WIDTH{~sleep_i}};
    c_din_en = c_din_enable_override_en | {`PORT_WIDTH{~sleep_i}};
    if (reset_pin_en)
      c_din_en[`PC_RESET_PIN] = 1'b0;
  end

  // ==========================================================
  // registered pad controls
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      portb_out_o    <= '0;
      portb_oe_n_o   <= '1;
      portb_pullup_o <= '0;
      portc_out_o    <= '0;
      portc_oe_n_o   <= '1;
      portc_pullup_o <= '0;
    end else begin
      for (int i = 0; i < `PORT_WIDTH; i++) begin
        logic [2:0] rb;
        logic [2:0] rc;
        rb = pad_resolve(b_pullup_override_en[i], b_pullup_override_val[i], b_dir_override_en[i], b_dir_override_val[i],
                         b_value_override_en[i], b_value_override_val[i], portb_dir_i[i],
                         portb_latch_i[i], global_pullup_disable_i);
        rc = pad_resolve(c_pullup_override_en[i], c_pullup_override_val[i], c_dir_override_en[i], c_dir_override_val[i],
                         c_value_override_en[i], c_value_override_val[i], portc_dir_i[i],
                         portc_latch_i[i], global_pullup_disable_i);
        portb_pullup_o[i] <= rb[2];
        portb_oe_n_o[i]   <= ~rb[1];
        portb_out_o[i]    <= rb[0];
        portc_pullup_o[i] <= rc[2];
        portc_oe_n_o[i]   <= ~rc[1];
        portc_out_o[i]    <= rc[0];
      end
    end
  end

  // ==========================================================
  // registered digital inputs to peripherals
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      portb_din_o            <= '0;
      portc_din_o            <= '0;
      spi_master_in_o        <= 1'b0;
      spi_slave_in_o         <= 1'b0;
      spi_clock_in_o         <= 1'b0;
      spi_slave_active_o     <= 1'b0;
      prog_data_in_o         <= 1'b0;
      prog_clock_o           <= 1'b0;
      pin_change_source_o    <= '0;
      timer1_count_input_o   <= 1'b0;
      timer1_capture_input_o <= 1'b0;
      ext_irq_source_4_o     <= 1'b0;
      ext_reset_n_o          <= 1'b1;
      one_wire_debug_line_o  <= 1'b1;
    end else begin
      portb_din_o <= portb_pad_i & b_din_en;
      portc_din_o <= portc_pad_i & c_din_en;
      spi_master_in_o <= portb_pad_i[`PB_MISO_PIN];
      spi_slave_in_o  <= portb_pad_i[`PB_MOSI_PIN];
      spi_clock_in_o  <= portb_pad_i[`PB_SERIAL_CLK];
      spi_slave_active_o <= (spi_role == SPI_SLAVE)
                            & ~portb_pad_i[`PB_SLAVE_SEL];
      prog_data_in_o  <= prog_mode_i & portb_pad_i[`PB_MOSI_PIN];
      prog_clock_o    <= prog_mode_i & portb_pad_i[`PB_SERIAL_CLK];
      pin_change_source_o[`PB_PCS_COUNT-1:0] <=
        portb_pad_i[`PB_PCS_COUNT-1:0] & b_din_enable_override_en[`PB_PCS_COUNT-1:0];
      pin_change_source_o[7]  <= 1'b0;
      pin_change_source_o[8]  <= portc_pad_i[`PC_CMP_A_PIN]
                                 & c_din_enable_override_en[`PC_CMP_A_PIN];
      pin_change_source_o[9]  <= portc_pad_i[`PC_CMP_B_PIN]
                                 & c_din_enable_override_en[`PC_CMP_B_PIN];
      pin_change_source_o[10] <= portc_pad_i[`PC_PCS10_PIN]
                                 & c_din_enable_override_en[`PC_PCS10_PIN];
      pin_change_source_o[11] <= portc_pad_i[`PC_PCS11_PIN]
                                 & c_din_enable_override_en[`PC_PCS11_PIN];
      timer1_count_input_o   <= portb_pad_i[`PB_COUNT_PIN];
      timer1_capture_input_o <= portc_pad_i[`PC_CAPTURE_PIN];
      ext_irq_source_4_o     <= portc_pad_i[`PC_CAPTURE_PIN]
                                & ext_irq_4_enable_i;
      ext_reset_n_o <= ~(reset_pin_en & ~debug_active)
                       | portc_pad_i[`PC_RESET_PIN];
      one_wire_debug_line_o <= ~debug_active
                               | portc_pad_i[`PC_RESET_PIN];
    end
  end

  // ==========================================================
  // checks
  property p_master_miso_in;
    @(posedge clk_i) disable iff (reset_i)
    (spi_role == SPI_MASTER && !prog_mode_i) |=> portb_oe_n_o[3];
  endproperty
  a_master_miso_in: assert property (p_master_miso_in)
    else $error("miso driven while spi master");

  property p_slave_mosi_in;
    @(posedge clk_i) disable iff (reset_i)
    (spi_role == SPI_SLAVE) |=> (portb_oe_n_o[2] && portb_oe_n_o[1]);
  endproperty
  a_slave_mosi_in: assert property (p_slave_mosi_in)
    else $error("mosi or clock driven while spi slave");

  property p_slave_sel_in;
    @(posedge clk_i) disable iff (reset_i)
    (spi_role == SPI_SLAVE) |=> portb_oe_n_o[0];
  endproperty
  a_slave_sel_in: assert property (p_slave_sel_in)
    else $error("select driven while spi slave");

  property p_slave_active;
    @(posedge clk_i) disable iff (reset_i)
    spi_slave_active_o |-> $past(portb_pad_i[0]) == 1'b0;
  endproperty
  a_slave_active: assert property (p_slave_active)
    else $error("slave active with select high");

  property p_forced_pullup;
    @(posedge clk_i) disable iff (reset_i)
    (spi_role == SPI_SLAVE) |=>
      portb_pullup_o[2] == ($past(portb_latch_i[2])
                            & ~$past(global_pullup_disable_i));
  endproperty
  a_forced_pullup: assert property (p_forced_pullup)
    else $error("forced input pull-up wrong");

  property p_cmp_a_needs_dir;
    @(posedge clk_i) disable iff (reset_i)
    !portc_dir_i[6] |=> portc_oe_n_o[6];
  endproperty
  a_cmp_a_needs_dir: assert property (p_cmp_a_needs_dir)
    else $error("compare a driven without direction bit");

  property p_reset_pin;
    @(posedge clk_i) disable iff (reset_i)
    (reset_pin_en && !debug_active) |=>
      (portc_pullup_o[1] && portc_oe_n_o[1] && !portc_din_o[1]);
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("reset pad not configured");

  property p_debug_gate;
    @(posedge clk_i) disable iff (reset_i)
    !debug_active |=> one_wire_debug_line_o;
  endproperty
  a_debug_gate: assert property (p_debug_gate)
    else $error("debug line active without fuse");

  property p_clock_out_fuse;
    @(posedge clk_i) disable iff (reset_i)
    (!sys_clock_output_fuse_i && !portc_dir_i[7]) |=> portc_oe_n_o[7];
  endproperty
  a_clock_out_fuse: assert property (p_clock_out_fuse)
    else $error("clock pad driven without fuse");

endmodule // port_b_c_alternate_function_override

// ### dv/pad_board_model.sv
// =====================================================================
// board side of one 8-bit port: spi peer, programmer, emulator, pulls
// assumes pad enables and values come from the design, the rest from
// the bench
module pad_board_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] pullup_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic      [7:0] pad_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_r = 8'h00;
  // an idle unpulled pad flips each cycle so no stale level is read
  always @(posedge clk_i) begin
    last_r <= pad_o;
  end
  // device driver, else outside party, else pull-up, else noise
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n_i[i]) pad_o[i] = out_i[i];
      else if (ext_en_i[i]) pad_o[i] = ext_val_i[i];
      else if (pullup_i[i]) pad_o[i] = 1'b1;
      else pad_o[i] = ~last_r[i];
    end
  end
endmodule // pad_board_model

// ### dv/port_b_c_alternate_function_override_tb_top.sv
// =====================================================================
// self-checking bench for the port b / port c override block
// assumes every output follows the inputs of the previous clock edge
module port_b_c_alternate_function_override_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 20000;
  logic clk_i = 1'b0, reset_i = 1'b1;
  logic [7:0] portb_dir_i, portb_latch_i, portc_dir_i, portc_latch_i;
  logic [7:0] pcs_mask_b_i, bx_en, bx_val, cx_en, cx_val;
  logic [3:0] pcs_mask_c_i;
  logic global_pullup_disable_i, sleep_i, spi_enable_bit_i;
  logic spi_master_select_i, spi_slave_out_i, spi_master_out_i;
  logic spi_clock_out_i, prog_mode_i, prog_data_out_i;
  logic pin_change_group_enable_i, pin_change_group_c_enable_i;
  logic timer1_compare_a_en_i, timer1_compare_a_out_i;
  logic timer1_compare_b_en_i, timer1_compare_b_out_i, ext_irq_4_enable_i;
  logic sys_clock_output_fuse_i, sys_clock_i, reset_disable_fuse_i;
  logic debug_enable_fuse_i, lock_bits_unprog_i, debug_tx_low_i;
  logic [7:0] portb_pad_i, portc_pad_i, portb_out_o, portb_oe_n_o;
  logic [7:0] portb_pullup_o, portb_din_o, portc_out_o, portc_oe_n_o;
  logic [7:0] portc_pullup_o, portc_din_o;
  logic spi_master_in_o, spi_slave_in_o, spi_clock_in_o;
  logic spi_slave_active_o, prog_data_in_o, prog_clock_o;
  logic timer1_count_input_o, timer1_capture_input_o, ext_irq_source_4_o;
  logic ext_reset_n_o, one_wire_debug_line_o;
  logic [11:0] pin_change_source_o;
  logic [15:0] lfsr_r = 16'h03AE, drv_prev;
  logic [86:0] seen, ex_q[$], mk_q[$];
  int n_errors = 0, n_tests = 0, cyc = 0;

  // =====================================================================
  // clock, design and board
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  port_b_c_alternate_function_override
    u_port_b_c_alternate_function_override (.*);
  pad_board_model u_board_b (.clk_i(clk_i), .oe_n_i(portb_oe_n_o),
    .out_i(portb_out_o), .pullup_i(portb_pullup_o), .ext_en_i(bx_en),
    .ext_val_i(bx_val), .pad_o(portb_pad_i));
  pad_board_model u_board_c (.clk_i(clk_i), .oe_n_i(portc_oe_n_o),
    .out_i(portc_out_o), .pullup_i(portc_pullup_o), .ext_en_i(cx_en),
    .ext_val_i(cx_val), .pad_o(portc_pad_i));
  assign seen = {portb_oe_n_o, portc_oe_n_o, portb_pullup_o,
    portc_pullup_o, portb_out_o, portc_out_o, portb_din_o, portc_din_o,
    pin_change_source_o, spi_master_in_o, spi_slave_in_o, spi_clock_in_o,
    spi_slave_active_o, prog_data_in_o, prog_clock_o, timer1_count_input_o,
    timer1_capture_input_o, ext_irq_source_4_o, ext_reset_n_o,
    one_wire_debug_line_o};

  // =====================================================================
  // helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [86:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apply(input logic [65:0] w);
    {portb_dir_i, portb_latch_i, portc_dir_i, portc_latch_i, pcs_mask_b_i,
     pcs_mask_c_i, global_pullup_disable_i, sleep_i, spi_enable_bit_i,
     spi_master_select_i, spi_slave_out_i, spi_master_out_i,
     spi_clock_out_i, prog_mode_i, prog_data_out_i,
     pin_change_group_enable_i, pin_change_group_c_enable_i,
     timer1_compare_a_en_i, timer1_compare_a_out_i, timer1_compare_b_en_i,
     timer1_compare_b_out_i, ext_irq_4_enable_i, sys_clock_output_fuse_i,
     sys_clock_i, reset_disable_fuse_i, debug_enable_fuse_i,
     lock_bits_unprog_i, debug_tx_low_i} = w;
  endtask

  // random inputs for one cycle, with the expected outputs noted
  task automatic step();
    logic [127:0] r;
    logic [7:0] bd, cd, bp, cp, bu, cu, bo, co, bm, cm, bi, ci;
    logic [11:0] pc;
    logic sm, ss, dbg, rst, global_pullup_disable;
    @(posedge clk_i);
    #1;
    for (int i = 0; i < 8; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      r[i*16 +: 16] = lfsr_r;
    end
    r[19] = r[19] & ~r[14]; // spi held off while programming
    apply(r[65:0]);
    global_pullup_disable = global_pullup_disable_i;
    sm = spi_enable_bit_i & spi_master_select_i;
    ss = spi_enable_bit_i & ~spi_master_select_i;
    dbg = debug_enable_fuse_i & lock_bits_unprog_i;
    rst = reset_disable_fuse_i & ~dbg;
    bd = portb_dir_i;
    if (ss) bd[2:0] = 3'h0;
    if (sm) bd[3] = 1'b0;
    if (prog_mode_i) bd[3] = 1'b1;
    cd = portc_dir_i;
    if (sys_clock_output_fuse_i) cd[7] = 1'b1;
    cd[1] = dbg ? debug_tx_low_i : (!rst && cd[1]);
    // outside parties drive only where neither old nor new driver is on
    bx_en = r[73:66] & ~bd & ~drv_prev[15:8] & 8'h7F;
    cx_en = r[81:74] & ~cd & ~drv_prev[7:0] & 8'hFE;
    bx_val = r[89:82];
    cx_val = r[97:90] & ~{6'h0, dbg, 1'b0};
    drv_prev = {bd, cd};
    #1;
    bp = portb_pad_i;
    cp = portc_pad_i;
    bu = ~portb_dir_i & portb_latch_i & {8{~global_pullup_disable}};
    if (sm) bu[3] = portb_latch_i[3] & ~global_pullup_disable;
    if (ss) bu[2:0] = portb_latch_i[2:0] & {3{~global_pullup_disable}};
    cu = ~portc_dir_i & portc_latch_i & {8{~global_pullup_disable}};
    cu[1] = cu[1] | rst | dbg;
    bo = portb_latch_i;
    if (ss) bo[3] = spi_slave_out_i;
    if (sm) bo[2:1] = {spi_master_out_i, spi_clock_out_i};
    if (prog_mode_i) bo[3] = prog_data_out_i;
    co = portc_latch_i;
    if (timer1_compare_a_en_i) co[6] = timer1_compare_a_out_i;
    if (timer1_compare_b_en_i) co[5] = timer1_compare_b_out_i;
    if (sys_clock_output_fuse_i) co[7] = sys_clock_i;
    if (dbg) co[1] = 1'b0;
    bm = {1'b0, pcs_mask_b_i[6:0] & {7{pin_change_group_enable_i}}};
    cm = {ext_irq_4_enable_i, {pcs_mask_c_i[0], pcs_mask_c_i[1],
      pcs_mask_c_i[2], 1'b0, pcs_mask_c_i[3], 2'h0}
      & {7{pin_change_group_c_enable_i}}};
    bi = bp & ({8{~sleep_i}} | bm);
    ci = cp & ({8{~sleep_i}} | cm);
    if (rst) ci[1] = 1'b0;
    pc = {{cp[2], cp[4], cp[5], cp[6]} & {4{pin_change_group_c_enable_i}},
      1'b0, bp[6:0] & {7{pin_change_group_enable_i}}};
    ex_q.push_back({~bd, ~cd, bu, cu, bo, co, bi, ci, pc, bp[3], bp[2],
      bp[1], ss & ~bp[0], prog_mode_i & bp[2], prog_mode_i & bp[1], bp[4],
      cp[7], cp[7] & ext_irq_4_enable_i, ~(rst & ~cp[1]),
      dbg ? cp[1] : 1'b1});
    mk_q.push_back({16'h7FFE, 8'h7F & ~{4'h0, prog_mode_i, 3'h0}, 8'hFE,
      bd & 8'h7F, cd & 8'hFE, 8'h7F, 8'hFE & ~{6'h0, dbg, 1'b0},
      pcs_mask_c_i, 1'b1, pcs_mask_b_i[6:0], 11'h7FF});
  endtask

  // =====================================================================
  // monitor: reset values, else the oldest note against the outputs
  always @(posedge clk_i) begin
    logic [86:0] e, m;
    #0.5;
    if (reset_i) check(seen, {16'hFFFF, 60'h0, 11'h003});
    else if (ex_q.size() > 0) begin
      e = ex_q.pop_front();
      m = mk_q.pop_front();
      check(seen[86:71] & m[86:71], e[86:71] & m[86:71]);
      check(seen[70:55] & m[70:55], e[70:55] & m[70:55]);
      check(seen[54:39] & m[54:39], e[54:39] & m[54:39]);
      check(seen[38:23] & m[38:23], e[38:23] & m[38:23]);
      check(seen[22:0] & m[22:0], e[22:0] & m[22:0]);
    end
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors = n_errors + 1;
      print_verdict();
    end
  end
  // main sequence: reset, random traffic, reset in mid-run, more traffic
  initial begin
    apply(66'h0);
    {bx_en, bx_val, cx_en, cx_val, drv_prev} = '0;
    repeat (16) @(posedge clk_i);
    #1 reset_i = 1'b0;
    repeat (3000) step();
    @(posedge clk_i);
    #1 reset_i = 1'b1;
    ex_q.delete();
    mk_q.delete();
    drv_prev = '0;
    repeat (4) @(posedge clk_i);
    #1 reset_i = 1'b0;
    repeat (1000) step();
    @(posedge clk_i);
    print_verdict();
  end
endmodule // port_b_c_alternate_function_override_tb_top
